// ===== src/tfw_tx_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "tfw_params.svh"
module tfw_tx_fifo
	import tfw_pkg::*;
#(
	parameter int DEPTH = `TFW_DEPTH_DEFAULT
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register writes
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire tfw_size_t wr_size,
	// register reads
	input wire logic rd_en,
	input wire logic [3:0] rd_addr,
	output logic [15:0] rd_data,
	// threshold command and interrupt
	input wire logic set_space_threshold_command,
	input wire logic [15:0] set_threshold_param,
	input wire logic space_irq_ack,
	output logic transmit_space_interrupt,
	// overrun indication
	input wire logic host_fault_clear,
	output logic host_fault_flag,
	// drain side towards the transmitter
	input wire logic drain_ready,
	output logic drain_valid,
	output logic [31:0] drain_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two, at least 2");
	end

	logic [31:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic next_drain_valid;
	logic [31:0] next_drain_data;
	logic port_write;
	logic commit_valid;
	logic [31:0] commit_data;
	logic [1:0] stage_count;
	logic full;
	logic push;
	logic pop;
	logic [31:0] free_wide;
	logic [15:0] free_bytes;
	logic [15:0] transmit_space_threshold;
	logic [15:0] next_threshold;
	tfw_irq_state_t irq_state;
	tfw_irq_state_t next_irq_state;
	logic next_irq;
	logic next_fault;
	logic [15:0] next_rd_data;

	assign port_write = wr_en && wr_addr == `TFW_OFF_WRITE_PORT;

	tfw_write_packer u_packer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wr_valid(port_write),
		.wr_data(wr_data),
		.wr_size(wr_size),
		.commit_valid(commit_valid),
		.commit_data(commit_data),
		.stage_count(stage_count)
	);

	// fifo storage; a commit into a full fifo is dropped
	always_comb begin
		full = count == (AW+1)'(DEPTH);
		push = commit_valid && !full;
		pop = count != '0 && (!drain_valid || drain_ready);
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		next_drain_data = pop ? mem[rd_ptr] : drain_data;
		next_drain_valid = pop || (drain_valid && !drain_ready);
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= commit_data;
		end
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			drain_valid <= 1'b0;
			drain_data <= 32'h00000000;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			drain_valid <= next_drain_valid;
			drain_data <= next_drain_data;
		end
	end

	// free space counts committed entries only, so partial staging
	// never shows; the output holding stage is not counted as space
	always_comb begin
		free_wide = (32'(DEPTH) - 32'(count)) << `TFW_LANE_SHIFT;
		if (free_wide > `TFW_FREE_SATURATE) begin
			free_bytes = 16'(`TFW_FREE_SATURATE);
		end else begin
			free_bytes = free_wide[15:0];
		end
	end

	// threshold and one-shot interrupt
	always_comb begin
		next_threshold = transmit_space_threshold;
		next_irq_state = irq_state;
		next_irq = transmit_space_interrupt;
		case (irq_state)
			TFW_ARMED: begin
				if (free_bytes > transmit_space_threshold) begin
					next_irq_state = TFW_RAISED;
					next_irq = 1'b1;
				end
			end
			TFW_RAISED: begin
				if (space_irq_ack) begin
					next_irq_state = TFW_SPENT;
					next_irq = 1'b0;
					next_threshold = `TFW_THRESH_DISABLE;
				end
			end
			default: begin
				next_irq = 1'b0;
			end
		endcase
		// a new command re-arms and withdraws any pending interrupt
		if (set_space_threshold_command) begin
			next_threshold = set_threshold_param;
			next_irq_state = TFW_ARMED;
			next_irq = 1'b0;
		end
		// set wins over clear so an overrun is never lost
		next_fault = host_fault_flag && !host_fault_clear;
		if (port_write && full) begin
			next_fault = 1'b1;
		end
		next_rd_data = 16'h0000;
		if (rd_en) begin
			case (rd_addr)
				`TFW_OFF_THRESHOLD: next_rd_data = transmit_space_threshold;
				`TFW_OFF_FREE: next_rd_data = free_bytes;
				default: next_rd_data = 16'h0000;
			endcase
		end else begin
			next_rd_data = rd_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			transmit_space_threshold <= `TFW_THRESH_DISABLE;
			irq_state <= TFW_SPENT;
			transmit_space_interrupt <= 1'b0;
			host_fault_flag <= 1'b0;
			rd_data <= 16'h0000;
		end else begin
			transmit_space_threshold <= next_threshold;
			irq_state <= next_irq_state;
			transmit_space_interrupt <= next_irq;
			host_fault_flag <= next_fault;
			rd_data <= next_rd_data;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// what a threshold read must return: the last command, or the
	// disable value once a raised interrupt has been acknowledged;
	// kept apart from the real register so read timing does not matter
	logic [15:0] ref_threshold;
	logic [15:0] next_ref_threshold;

	always_comb begin
		next_ref_threshold = ref_threshold;
		if (set_space_threshold_command) begin
			next_ref_threshold = set_threshold_param;
		end else if (transmit_space_interrupt && space_irq_ack) begin
			next_ref_threshold = `TFW_THRESH_DISABLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ref_threshold <= `TFW_THRESH_DISABLE;
		end else begin
			ref_threshold <= next_ref_threshold;
		end
	end

	a_threshold_read_back: assert property (
		rd_en && rd_addr == `TFW_OFF_THRESHOLD
		|=> rd_data == $past(ref_threshold))
		else $error("threshold read differs from command");
	a_irq_needs_space: assert property (
		$rose(transmit_space_interrupt)
		|-> $past(free_bytes > transmit_space_threshold))
		else $error("interrupt without enough space");
	a_ack_disables: assert property (
		transmit_space_interrupt && space_irq_ack &&
		!set_space_threshold_command
		|=> transmit_space_threshold == `TFW_THRESH_DISABLE &&
		!transmit_space_interrupt)
		else $error("ack did not disable threshold");
	a_one_irq_per_cmd: assert property (
		irq_state == TFW_SPENT && !set_space_threshold_command
		|=> !transmit_space_interrupt && irq_state == TFW_SPENT)
		else $error("second interrupt without command");
	a_free_read: assert property (
		rd_en && rd_addr == `TFW_OFF_FREE
		|=> rd_data == $past(free_bytes) && rd_data[1:0] == 2'h0)
		else $error("free read wrong");
	a_free_zero_full: assert property (
		full |-> free_bytes == 16'h0000)
		else $error("free not zero when full");
	a_overrun_flag: assert property (
		port_write && full |=> host_fault_flag)
		else $error("overrun not flagged");
	a_commit_counts: assert property (
		push && !pop |=> count == $past(count) + 1'b1)
		else $error("commit did not add one entry");
	a_partial_hidden: assert property (
		port_write && !commit_valid && !pop |=> count == $past(count))
		else $error("partial write changed the entry count");
	c_irq_raised: cover property ($rose(transmit_space_interrupt));
	c_ack_spent: cover property (transmit_space_interrupt && space_irq_ack);
	c_fifo_full: cover property (full && port_write);
	c_partial_staged: cover property (
		stage_count != 2'h0 && rd_en && rd_addr == `TFW_OFF_FREE);
endmodule // tfw_tx_fifo
`default_nettype wire

// ===== src/tfw_params.svh
// Overview of operation
// - threshold register returns last commanded threshold value, or the disable value after an acknowledge
// - interrupt when free bytes exceed threshold
// - each data port write pushes its bytes; the code pushes only whole dwords and drops one committed while full
// - byte, word, dword writes mix freely
// - bytes packed little-endian into 32-bit entries
// - free count real-time, saturates, zero when full
// - free count whole dwords, low bits zero
// - write while full sets host fault flag
`ifndef TFW_PARAMS_SVH
`define TFW_PARAMS_SVH
`define TFW_OFF_WRITE_PORT 4'h0
`define TFW_OFF_THRESHOLD 4'h2
`define TFW_OFF_FREE 4'hC
`define TFW_THRESH_DISABLE 16'h1FFC
`define TFW_FREE_SATURATE 32'h0000FFFF
`define TFW_LANES 3'h4
`define TFW_LANE_SHIFT 2
`define TFW_DEPTH_DEFAULT 1024
`endif

// ===== src/tfw_pkg.sv
package tfw_pkg;
	// write size encoding on the wr_size port
	typedef enum logic [1:0] {
		TFW_SIZE_BYTE,
		TFW_SIZE_WORD,
		TFW_SIZE_DWORD
	} tfw_size_t;
	// threshold interrupt life cycle
	typedef enum logic [1:0] {
		TFW_ARMED,
		TFW_RAISED,
		TFW_SPENT
	} tfw_irq_state_t;
endpackage

// ===== src/tfw_write_packer.sv
`timescale 1ns/100ps
`default_nettype none
`include "tfw_params.svh"
module tfw_write_packer
	import tfw_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// host data write
	input wire logic wr_valid,
	input wire logic [31:0] wr_data,
	input wire tfw_size_t wr_size,
	// committed entry and staged byte count
	output logic commit_valid,
	output logic [31:0] commit_data,
	output logic [1:0] stage_count
);
	logic [31:0] stage;
	logic [31:0] next_stage;
	logic [1:0] next_count;
	logic [2:0] nbytes;
	logic [2:0] total;
	logic [31:0] masked;
	logic [63:0] ext;

	always_comb begin
		case (wr_size)
			TFW_SIZE_BYTE: begin
				nbytes = 3'h1;
				masked = {24'h000000, wr_data[7:0]};
			end
			TFW_SIZE_WORD: begin
				nbytes = 3'h2;
				masked = {16'h0000, wr_data[15:0]};
			end
			default: begin
				nbytes = `TFW_LANES;
				masked = wr_data;
			end
		endcase
		// new bytes land right after the staged ones
		ext = {32'h00000000, stage} |
			({32'h00000000, masked} << {stage_count, 3'h0});
		total = {1'b0, stage_count} + nbytes;
		next_stage = stage;
		next_count = stage_count;
		commit_valid = 1'b0;
		commit_data = ext[31:0];
		if (wr_valid) begin
			if (total >= `TFW_LANES) begin
				commit_valid = 1'b1;
				next_stage = ext[63:32];
				next_count = 2'(total - `TFW_LANES);
			end else begin
				next_stage = ext[31:0];
				next_count = total[1:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			stage <= 32'h00000000;
			stage_count <= 2'h0;
		end else begin
			stage <= next_stage;
			stage_count <= next_count;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_pack_count: assert property (
		wr_valid |=> stage_count ==
		2'($past(stage_count) + $past(nbytes)))
		else $error("staged byte count wrong");
	a_pack_byte_lane: assert property (
		wr_valid && wr_size == TFW_SIZE_BYTE && stage_count == 2'h1
		|=> stage[15:8] == $past(wr_data[7:0]))
		else $error("byte not in next lane");
	a_pack_commit: assert property (
		wr_valid && wr_size == TFW_SIZE_DWORD |-> commit_valid)
		else $error("dword write did not commit");
	c_pack_split: cover property (wr_valid && commit_valid &&
		stage_count == 2'h3 && wr_size == TFW_SIZE_DWORD);
endmodule // tfw_write_packer
`default_nettype wire

// ===== dv/tfw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module tfw_host_model
	import tfw_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register bus
	output var logic wr_en,
	output var logic [3:0] wr_addr,
	output var logic [31:0] wr_data,
	output var tfw_size_t wr_size,
	output var logic rd_en,
	output var logic [3:0] rd_addr,
	input wire logic [15:0] rd_data,
	// command pulses
	output var logic cmd,
	output var logic [15:0] param,
	output var logic ack,
	output var logic fclr
);
	initial begin
		{wr_en, rd_en, cmd, ack, fclr} = 5'h00;
		{wr_addr, rd_addr, param} = 24'h000000;
		wr_data = 32'h00000000;
		wr_size = TFW_SIZE_BYTE;
	end
	// bytes always start at lane zero
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input tfw_size_t s);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		wr_size <= s;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		// released bus must not keep showing the old data
		wr_data <= ~d;
	endtask
	// free count also read with bytes staged mid dword, no bus mastering
	task automatic rd(input logic [3:0] a, output logic [15:0] q);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(posedge ref_clk);
		#1 q = rd_data;
	endtask
	// k: 0 threshold command, 1 acknowledge, 2 fault clear
	task automatic pulse(input int k, input logic [15:0] p);
		@(posedge ref_clk);
		param <= p;
		{fclr, ack, cmd} <= 3'(1 << k);
		@(posedge ref_clk);
		{fclr, ack, cmd} <= 3'h0;
	endtask
endmodule // tfw_host_model
`default_nettype wire

// ===== dv/tx_fifo_host_write_side_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tx_fifo_host_write_side_bench
	import tfw_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic drain_ready = 1'b0;
	logic wr_en, rd_en, cmd, ack, fclr, irq, fault, dvalid;
	logic [3:0] wr_addr, rd_addr;
	logic [31:0] wr_data, ddata;
	logic [15:0] rd_data, param, q;
	tfw_size_t wr_size;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	int nent;
	always #50 ref_clk = ~ref_clk;
	tfw_tx_fifo #(.DEPTH(4)) dut(.ref_clk(ref_clk), .resetn(resetn),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_size(wr_size), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data), .set_space_threshold_command(cmd),
		.set_threshold_param(param), .space_irq_ack(ack),
		.transmit_space_interrupt(irq), .host_fault_clear(fclr),
		.host_fault_flag(fault), .drain_ready(drain_ready),
		.drain_valid(dvalid), .drain_data(ddata));
	tfw_host_model host(.ref_clk(ref_clk), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_size(wr_size),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .cmd(cmd),
		.param(param), .ack(ack), .fclr(fclr));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] ent(input int n);
		return {8'(4 * n + 3), 8'(4 * n + 2), 8'(4 * n + 1), 8'(4 * n)};
	endfunction
	task automatic wrap_up;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic t_reset;
		host.rd(4'h2, q);
		chk(q, 16'h1FFC);
		host.rd(4'hC, q);
		chk(q, 16'h0010);
		host.rd(4'h4, q);
		chk(q, 16'h0000);
		chk(irq, 1'b0);
	endtask
	// junk in unused lanes must not be pushed
	task automatic t_pack_fill;
		host.wr(4'h0, 32'hAAAAAA00, TFW_SIZE_BYTE);
		host.wr(4'h0, 32'hBBBB0201, TFW_SIZE_WORD);
		host.rd(4'hC, q);
		chk(q, 16'h0010);
		host.wr(4'h0, 32'h06050403, TFW_SIZE_DWORD);
		host.wr(4'h0, 32'hCCCCCC07, TFW_SIZE_BYTE);
		host.wr(4'h8, 32'hDEADBEEF, TFW_SIZE_DWORD);
		for (nent = 2; nent < 8; nent++) begin
			host.rd(4'hC, q);
			chk(q[1:0], 2'h0);
			if (q === 16'h0000)
				break;
			host.wr(4'h0, ent(nent), TFW_SIZE_DWORD);
		end
		chk(q, 16'h0000);
		chk(fault, 1'b0);
		host.wr(4'h0, 32'hEEEEEEEE, TFW_SIZE_DWORD);
		@(posedge ref_clk);
		#1 chk(fault, 1'b1);
		host.pulse(2, 16'h0000);
		@(posedge ref_clk);
		#1 chk(fault, 1'b0);
	endtask
	// transmitter stalls between words, order must survive
	task automatic t_drain;
		for (int n = 0; n < nent; n++) begin
			chk(dvalid, 1'b1);
			chk(ddata, ent(n));
			@(posedge ref_clk);
			drain_ready <= 1'b1;
			@(posedge ref_clk);
			drain_ready <= 1'b0;
			repeat (2) @(posedge ref_clk);
			#1;
		end
		chk(dvalid, 1'b0);
	endtask
	task automatic t_irq;
		host.rd(4'hC, q);
		chk(q, 16'h0010);
		host.pulse(0, 16'h0010);
		host.rd(4'h2, q);
		chk(q, 16'h0010);
		chk(irq, 1'b0);
		host.pulse(0, 16'h000C);
		host.rd(4'h2, q);
		chk(q, 16'h000C);
		chk(irq, 1'b1);
		host.pulse(1, 16'h0000);
		@(posedge ref_clk);
		#1 chk(irq, 1'b0);
		host.rd(4'h2, q);
		chk(q, 16'h1FFC);
		repeat (4) @(posedge ref_clk);
		#1 chk(irq, 1'b0);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_pack_fill();
		t_drain();
		t_irq();
		wrap_up();
	end
endmodule // tx_fifo_host_write_side_bench
`default_nettype wire
